/* design/bnqc_cfg.svh */
// constants of the band norm quantizer and envelope coder
`ifndef BNQC_CFG_SVH
`define BNQC_CFG_SVH
`define BNQC_IDX_BIAS     6'h22
`define BNQC_IDX_MAX0     6'h1F
`define BNQC_IDX_MAXN     6'h27
`define BNQC_NEG_LIM      6'h0F
`define BNQC_POS_LIM      6'h10
`define BNQC_ADJ_OFS      8'h0F
`define BNQC_FIRST_W      5'h05
`define BNQC_MODE_W       5'h02
`define BNQC_PACK_W       5'h05
`define BNQC_BANDS_WB     6'h1A
`define BNQC_BANDS_FB     6'h2C
`define BNQC_BANDS_SWB    6'h27
`define BNQC_MODE_CTX     2'h0
`define BNQC_MODE_RSZ     2'h1
`define BNQC_MODE_NRM     2'h2
`define BNQC_MODE_PACK    2'h3
`define BNQC_BW_WB        2'h0
`define BNQC_BW_FB        2'h1
`define BNQC_BW_SWB       2'h2
`endif

/* design/bnqc_fifo.sv */
// symbol fifo with registered output stage
`timescale 1ns/1ns
`default_nettype none
module bnqc_fifo #(
  parameter int W = 22,
  parameter int D = 16
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         ce,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  // full and empty from the word count; output register refills on pop
  assign in_ready = (cnt_q != D[AW:0]);
  assign push     = in_valid && in_ready;
  assign pop      = (cnt_q != '0) && (!out_valid || out_ready);

  // storage array
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wr_q] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
    end
  end

  // output stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (ce) begin
      if (pop) begin
        out_valid <= 1'b1;
        out_data  <= mem[rd_q];
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  hold_stall_a: assert property (ce && out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("fifo output changed while stalled");
endmodule
`default_nettype wire

/* design/bnqc_pkg.sv */
// types of the band norm quantizer and envelope coder
`include "bnqc_cfg.svh"
package bnqc_pkg;
  typedef enum logic [6:0] {
    ST_COLLECT = 7'h01,
    ST_DIV     = 7'h02,
    ST_QUANT   = 7'h04,
    ST_PASS1   = 7'h08,
    ST_PASS2   = 7'h10,
    ST_COST    = 7'h20,
    ST_EMIT    = 7'h40
  } bnqc_state_t;
  typedef enum logic [1:0] {
    MODE_CTX  = `BNQC_MODE_CTX,
    MODE_RSZ  = `BNQC_MODE_RSZ,
    MODE_NRM  = `BNQC_MODE_NRM,
    MODE_PACK = `BNQC_MODE_PACK
  } bnqc_mode_t;
endpackage

/* design/bnqc_top.sv */
// band norm quantizer and envelope coder
// Notes on behaviour
// - band energy is rms over band coefficients
// - forty level log quantizer, 3 dB steps
// - index is 34 minus twice log2 energy
// - band 0 clipped to 31, others 39
// - index i means level 2^(17-i/2)
// - band 0 raw, then neighbour differences
// - downward pass lifts drops below -15
// - upward pass caps rises at 16
// - adjusted difference is difference plus 15
// - first index written as 5 bits
// - cheapest of four modes, 2-bit field
// - modes: 0 context, 1 resized, 2 normal, 3 pack
// - context: first from index, then previous difference
// - pack mode writes 5-bit fields
// - normal mode uses fixed 3-7 bit codes
// - resized mode uses lower-rate code table
// - band count 26, 44 or 39 by bandwidth
`timescale 1ns/1ns
`default_nettype none
`include "bnqc_cfg.svh"
module bnqc_top
  import bnqc_pkg::*;
#(
  parameter int COEF_W = 16,
  parameter int ACC_W  = 40,
  parameter int FIFO_D = 16
) (
  // clock, reset, enable
  input  wire logic              MCLK,
  input  wire logic              ARST_N,
  input  wire logic              CE,
  // frame setup
  input  wire logic [1:0]        BW_SEL,
  input  wire logic [5:0]        CTX_OFFSET,
  // coefficient stream
  input  wire logic              COEF_VALID,
  output logic                   COEF_READY,
  input  wire logic [COEF_W-1:0] COEF_DATA,
  input  wire logic              COEF_BAND_END,
  // code table load
  input  wire logic              TBL_WE,
  input  wire logic              TBL_SEL,
  input  wire logic [9:0]        TBL_ADDR,
  input  wire logic [4:0]        TBL_LEN,
  input  wire logic [15:0]       TBL_CODE,
  // symbol stream to bitstream writer
  output logic                   SYM_VALID,
  input  wire logic              SYM_READY,
  output logic [15:0]            SYM_CODE,
  output logic [4:0]             SYM_LEN,
  output logic                   SYM_LAST,
  // frame status
  output logic                   FRAME_DONE,
  output logic [1:0]             MODE_OUT
);
  bnqc_state_t   state_q;
  bnqc_mode_t    mode_q;
  logic [5:0]    norm_q [44];
  logic [4:0]    rsz_len [32];
  logic [15:0]   rsz_code [32];
  logic [4:0]    ctx_len [1024];
  logic [15:0]   ctx_code [1024];
  logic [ACC_W-1:0] acc_q;
  logic [7:0]    rem_q;
  logic [6:0]    len_q;
  logic [5:0]    div_cnt_q;
  logic [5:0]    band_q;
  logic [5:0]    nb_q;
  logic [5:0]    b_q;
  logic [1:0]    ph_q;
  logic [10:0]   cost_ctx_q;
  logic [10:0]   cost_rsz_q;
  logic [10:0]   cost_nrm_q;
  logic          take;
  logic [ACC_W-1:0] sq;
  logic [7:0]    div_r;
  logic          div_ge;
  logic [5:0]    q_idx;
  logic [5:0]    n_lo;
  logic [5:0]    n_hi;
  logic [4:0]    adj;
  logic [4:0]    ctx;
  logic [20:0]   nrm;
  logic [10:0]   cost_pack;
  logic          push;
  logic          fifo_rdy;
  logic [21:0]   sym_d;

  // normal code table: {length, right aligned code}
  function automatic logic [20:0] nrm_code(input logic [4:0] i);
    logic [20:0] r;
    r = '0;
    if (i <= 5'h07 || i >= 5'h18) r = {5'h07, 9'h000, i[1:0], 2'h3, i[4], 1'b1, i[2]};
    else if ((i >= 5'h08 && i <= 5'h0B) || (i >= 5'h14 && i <= 5'h17)) r = {5'h06, 10'h000, i[1:0], 2'h3, i[4], 1'b0};
    else if (i == 5'h0C || i == 5'h0D || i == 5'h12 || i == 5'h13) r = {5'h04, 12'h000, i[1:0], 2'h2};
    else r = {5'h03, 13'h0000, i[1:0], 1'b0};
    return r;
  endfunction

  // rounded log2 of the band mean; 1.5 stands in for sqrt 2
  function automatic logic [5:0] log2r(input logic [ACC_W-1:0] v);
    logic [5:0] p;
    p = '0;
    for (int k = 0; k < ACC_W; k++) begin
      if (v[k]) p = k[5:0];
    end
    if (p != 6'h00 && v[p-6'h01]) p = p + 6'h01;
    return p;
  endfunction

  // band count of the chosen bandwidth
  function automatic logic [5:0] bands(input logic [1:0] s);
    logic [5:0] n;
    n = `BNQC_BANDS_SWB;
    if (s == `BNQC_BW_WB) n = `BNQC_BANDS_WB;
    else if (s == `BNQC_BW_FB) n = `BNQC_BANDS_FB;
    return n;
  endfunction

  // offset difference of two neighbour indices
  function automatic logic [4:0] adjf(input logic [5:0] hi, input logic [5:0] lo);
    logic [7:0] d;
    d = {2'b00, hi} - {2'b00, lo} + `BNQC_ADJ_OFS;
    return d[4:0];
  endfunction

  // squared coefficient and divider step
  assign take  = state_q == ST_COLLECT && COEF_VALID && COEF_READY;
  assign sq    = ACC_W'($signed(COEF_DATA) * $signed(COEF_DATA));
  assign div_r = {rem_q[6:0], acc_q[ACC_W-1]};
  assign div_ge = div_r >= {1'b0, len_q};

  // index from mean energy with saturation
  always_comb begin
    q_idx = (band_q == 6'h00) ? `BNQC_IDX_MAX0 : `BNQC_IDX_MAXN;
    if (acc_q != '0 && log2r(acc_q) >= `BNQC_IDX_BIAS) q_idx = 6'h00;
    else if (acc_q != '0 && (`BNQC_IDX_BIAS - log2r(acc_q)) < q_idx)
      q_idx = `BNQC_IDX_BIAS - log2r(acc_q);
  end

  // neighbour pair at the walking band, its adjusted difference and context
  assign n_lo = norm_q[b_q];
  assign n_hi = norm_q[b_q + 6'h01];
  assign adj  = adjf(n_hi, n_lo);
  assign ctx  = (b_q == 6'h00) ? 5'(norm_q[0] - CTX_OFFSET) : adjf(n_lo, norm_q[b_q - 6'h01]);
  assign nrm  = nrm_code(adj);
  assign cost_pack = 11'(`BNQC_PACK_W * (nb_q - 6'h01));

  // loadable code tables
  always_ff @(posedge MCLK) begin
    if (CE && TBL_WE) begin
      if (TBL_SEL) begin
        ctx_len[TBL_ADDR]  <= TBL_LEN;
        ctx_code[TBL_ADDR] <= TBL_CODE;
      end else begin
        rsz_len[TBL_ADDR[4:0]]  <= TBL_LEN;
        rsz_code[TBL_ADDR[4:0]] <= TBL_CODE;
      end
    end
  end

  // energy accumulation and division by band length
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      acc_q <= '0;
      rem_q <= '0;
      len_q <= '0;
    end else if (CE) begin
      if (take) begin
        acc_q <= ((len_q == 7'h00) ? '0 : acc_q) + sq;
        len_q <= len_q + 7'h01;
        rem_q <= '0;
      end else if (state_q == ST_DIV) begin
        rem_q <= div_ge ? div_r - {1'b0, len_q} : div_r;
        acc_q <= {acc_q[ACC_W-2:0], div_ge};
      end else if (state_q == ST_QUANT) begin
        len_q <= '0;
      end
    end
  end

  // norm index memory: quantize, then the two limiting passes
  always_ff @(posedge MCLK) begin
    if (CE) begin
      if (state_q == ST_QUANT) norm_q[band_q] <= q_idx;
      else if (state_q == ST_PASS1 && n_lo > n_hi + `BNQC_NEG_LIM) norm_q[b_q] <= n_hi;
      else if (state_q == ST_PASS2 && n_hi > n_lo + `BNQC_POS_LIM)
        norm_q[b_q + 6'h01] <= n_lo + `BNQC_POS_LIM;
    end
  end

  // bit costs of the table driven modes
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cost_ctx_q <= '0;
      cost_rsz_q <= '0;
      cost_nrm_q <= '0;
    end else if (CE) begin
      if (state_q == ST_PASS2) begin
        cost_ctx_q <= '0;
        cost_rsz_q <= '0;
        cost_nrm_q <= '0;
      end else if (state_q == ST_COST) begin
        cost_ctx_q <= cost_ctx_q + 11'(ctx_len[{ctx, adj}]);
        cost_rsz_q <= cost_rsz_q + 11'(rsz_len[adj]);
        cost_nrm_q <= cost_nrm_q + 11'(nrm[20:16]);
      end
    end
  end

  // symbol for the fifo: first index, mode, then one code per difference
  always_comb begin
    sym_d = {1'b0, 5'h00, 16'h0000};
    if (ph_q == 2'h0) sym_d = {1'b0, `BNQC_FIRST_W, 10'h000, norm_q[0]};
    else if (ph_q == 2'h1) sym_d = {1'b0, `BNQC_MODE_W, 14'h0000, mode_q};
    else begin
      case (mode_q)
        MODE_CTX: sym_d = {1'b0, ctx_len[{ctx, adj}], ctx_code[{ctx, adj}]};
        MODE_RSZ: sym_d = {1'b0, rsz_len[adj], rsz_code[adj]};
        MODE_NRM: sym_d = {1'b0, nrm};
        default:  sym_d = {1'b0, `BNQC_PACK_W, 11'h000, adj};
      endcase
      sym_d[21] = (b_q == nb_q - 6'h02);
    end
  end
  assign push = state_q == ST_EMIT && fifo_rdy;

  // frame sequencer
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q    <= ST_COLLECT;
      COEF_READY <= 1'b1;
      div_cnt_q  <= '0;
      band_q     <= '0;
      nb_q       <= `BNQC_BANDS_WB;
      b_q        <= '0;
      ph_q       <= '0;
      mode_q     <= MODE_PACK;
      FRAME_DONE <= 1'b0;
      MODE_OUT   <= `BNQC_MODE_PACK;
    end else if (CE) begin
      FRAME_DONE <= 1'b0;
      case (state_q)
        ST_COLLECT: begin
          if (take && band_q == 6'h00 && len_q == 7'h00) nb_q <= bands(BW_SEL);
          if (take && COEF_BAND_END) begin
            state_q    <= ST_DIV;
            COEF_READY <= 1'b0;
            div_cnt_q  <= 6'(ACC_W - 1);
          end
        end
        ST_DIV: begin
          div_cnt_q <= div_cnt_q - 6'h01;
          if (div_cnt_q == 6'h00) state_q <= ST_QUANT;
        end
        ST_QUANT: begin
          if (band_q == nb_q - 6'h01) begin
            state_q <= ST_PASS1;
            band_q  <= '0;
            b_q     <= nb_q - 6'h02;
          end else begin
            state_q    <= ST_COLLECT;
            COEF_READY <= 1'b1;
            band_q     <= band_q + 6'h01;
          end
        end
        ST_PASS1: begin
          if (b_q == 6'h00) state_q <= ST_PASS2;
          else b_q <= b_q - 6'h01;
        end
        ST_PASS2: begin
          b_q <= b_q + 6'h01;
          if (b_q == nb_q - 6'h02) begin
            state_q <= ST_COST;
            b_q     <= '0;
          end
        end
        ST_COST: begin
          b_q <= b_q + 6'h01;
          if (b_q == nb_q - 6'h02) begin
            state_q <= ST_EMIT;
            b_q     <= '0;
            ph_q    <= '0;
          end
        end
        ST_EMIT: begin
          if (ph_q == 2'h0 && push) begin
            // final cost sums are ready now; lowest mode wins ties
            if (cost_ctx_q <= cost_rsz_q && cost_ctx_q <= cost_nrm_q && cost_ctx_q <= cost_pack)
              mode_q <= MODE_CTX;
            else if (cost_rsz_q <= cost_nrm_q && cost_rsz_q <= cost_pack) mode_q <= MODE_RSZ;
            else if (cost_nrm_q <= cost_pack) mode_q <= MODE_NRM;
            else mode_q <= MODE_PACK;
          end
          if (push) begin
            if (ph_q != 2'h2) ph_q <= ph_q + 2'h1;
            else if (b_q == nb_q - 6'h02) begin
              state_q    <= ST_COLLECT;
              COEF_READY <= 1'b1;
              FRAME_DONE <= 1'b1;
              MODE_OUT   <= mode_q;
            end else b_q <= b_q + 6'h01;
          end
        end
        default: begin
          state_q    <= ST_COLLECT;
          COEF_READY <= 1'b1;
        end
      endcase
    end
  end

  bnqc_fifo #(.W(22), .D(FIFO_D)) u_fifo (
    .clk       (MCLK),
    .arst_n    (ARST_N),
    .ce        (CE),
    .in_valid  (state_q == ST_EMIT),
    .in_ready  (fifo_rdy),
    .in_data   (sym_d),
    .out_valid (SYM_VALID),
    .out_ready (SYM_READY),
    .out_data  ({SYM_LAST, SYM_LEN, SYM_CODE})
  );

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  sequence s_band_end;
    CE && take && COEF_BAND_END;
  endsequence
  sequence s_divide;
    (state_q == ST_DIV) [*8];
  endsequence
  ready_in_collect_a: assert property (COEF_READY |-> state_q == ST_COLLECT)
    else $error("input ready outside collection");
  band_divide_a: assert property (s_band_end |=> s_divide)
    else $error("band end not followed by division");
  first_clip_a: assert property (CE && state_q == ST_QUANT && band_q == 6'h00 |-> q_idx <= 6'h1F)
    else $error("lowest band index above 31");
  other_clip_a: assert property (CE && state_q == ST_QUANT |-> q_idx <= 6'h27)
    else $error("band index above 39");
  drop_limit_a: assert property (CE && state_q == ST_PASS1 && n_lo > n_hi + 6'h0F |=> norm_q[$past(b_q)] == $past(n_hi))
    else $error("steep drop not lifted");
  rise_limit_a: assert property (CE && state_q == ST_COST |-> n_hi <= n_lo + 6'h10 && n_lo <= n_hi + 6'h0F)
    else $error("difference outside range after passes");
  first_width_a: assert property (push && ph_q == 2'h0 |-> sym_d[20:16] == 5'h05 && sym_d[15:0] == 16'(norm_q[0]))
    else $error("first index symbol wrong");
  mode_field_a: assert property (push && ph_q == 2'h1 |-> sym_d[20:16] == 5'h02 && (mode_q != MODE_PACK
    || cost_pack <= cost_nrm_q))
    else $error("mode symbol wrong or pack not cheapest");
  pack_width_a: assert property (push && ph_q == 2'h2 && mode_q == MODE_PACK |-> sym_d[20:16] == 5'h05)
    else $error("packed difference not 5 bits");
  normal_len_a: assert property (push && ph_q == 2'h2 && mode_q == MODE_NRM
    |-> sym_d[20:16] >= 5'h03 && sym_d[20:16] <= 5'h07 && (adj != 5'h10 || sym_d[15:0] == 16'h0000)
    && (adj != 5'h06 || sym_d[15:0] == 16'h005B))
    else $error("normal code length wrong");
endmodule
`default_nettype wire

/* verification/bnqc_top_test.sv */
// self-checking bench for the band norm envelope coder
`timescale 1ns/1ns
`default_nettype none
module bnqc_top_test;
  import bnqc_pkg::*;
  logic        mclk, arst_n, ce, coef_valid, coef_ready, coef_band_end, tbl_we, tbl_sel;
  logic        sym_valid, sym_ready, sym_last, frame_done, stall, clr;
  logic [1:0]  bw_sel, mode_out, exp_mode;
  logic [5:0]  ctx_offset;
  logic [15:0] coef_data, tbl_code, sym_code;
  logic [9:0]  tbl_addr;
  logic [4:0]  tbl_len, sym_len;
  int          num_errors, checks_done, cyc, rlen, clen, nb;
  int          raw [0:43];
  int          ix  [0:43];
  logic [21:0] exp_q [0:63];
  logic [6:0]  nc [0:31] = '{7'h1A, 7'h3A, 7'h5A, 7'h7A, 7'h1B, 7'h3B, 7'h5B, 7'h7B, 7'h0C, 7'h1C, 7'h2C,
    7'h3C, 7'h02, 7'h06, 7'h04, 7'h06, 7'h00, 7'h02, 7'h0A, 7'h0E, 7'h0E, 7'h1E, 7'h2E, 7'h3E, 7'h1E,
    7'h3E, 7'h5E, 7'h7E, 7'h1F, 7'h3F, 7'h5F, 7'h7F};

  bnqc_top bnqc_top_inst (.MCLK(mclk), .ARST_N(arst_n), .CE(ce), .BW_SEL(bw_sel), .CTX_OFFSET(ctx_offset),
    .COEF_VALID(coef_valid), .COEF_READY(coef_ready), .COEF_DATA(coef_data), .COEF_BAND_END(coef_band_end),
    .TBL_WE(tbl_we), .TBL_SEL(tbl_sel), .TBL_ADDR(tbl_addr), .TBL_LEN(tbl_len), .TBL_CODE(tbl_code),
    .SYM_VALID(sym_valid), .SYM_READY(sym_ready), .SYM_CODE(sym_code), .SYM_LEN(sym_len),
    .SYM_LAST(sym_last), .FRAME_DONE(frame_done), .MODE_OUT(mode_out));
  bnqc_writer_model bnqc_writer_model_inst (.clk(mclk), .arst_n(arst_n), .stall(stall), .clr(clr),
    .sym_valid(sym_valid), .sym_ready(sym_ready), .sym_code(sym_code), .sym_len(sym_len), .sym_last(sym_last));

  // normal code lengths: 3 near zero difference, up to 7 at the extremes
  function automatic int nlen(int a);
    return (a < 8 || a > 23) ? 7 : (a < 12 || a > 19) ? 6 : (a == 12 || a == 13 || a == 18 || a == 19) ? 4 : 3;
  endfunction
  function automatic int msk(int a, int l);
    return a & ((1 << l) - 1);
  endfunction
  function automatic logic [21:0] sym(int last, int len, int code);
    return {last[0], len[4:0], code[15:0]};
  endfunction

  task automatic cmp_sym(logic [21:0] got, logic [21:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(logic [1:0] got, logic [1:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // fill both loadable tables, every entry of a table with one length
  task automatic load_tbls(int rl, int cl);
    int ad;
    int ln;
    rlen = rl;
    clen = cl;
    for (int a = 0; a < 1056; a++) begin
      ad = a < 32 ? a : a - 32;
      ln = a < 32 ? rl : cl;
      @(negedge mclk);
      tbl_we = 1'b1;
      tbl_sel = a >= 32;
      tbl_addr = 10'(ad);
      tbl_len = 5'(ln);
      tbl_code = 16'(msk(ad, ln));
    end
    @(negedge mclk);
    tbl_we = 1'b0;
  endtask

  // reference envelope: clip, two limiting passes, mode costs, symbols
  task automatic build_exp();
    int d;
    int m;
    int cx;
    int cost [0:3];
    int adj [0:42];
    for (int b = 0; b < nb; b++) ix[b] = raw[b] > 39 ? 39 : raw[b];
    ix[0] = ix[0] > 31 ? 31 : ix[0];
    for (int b = nb - 2; b >= 0; b--) if (ix[b + 1] - ix[b] < -15) ix[b] = ix[b + 1];
    cost = '{0, 0, 0, 0};
    for (int b = 0; b < nb - 1; b++) begin
      d = ix[b + 1] - ix[b];
      if (d > 16) begin
        d = 16;
        ix[b + 1] = ix[b] + 16;
      end
      adj[b] = d + 15;
      cost[0] += clen;
      cost[1] += rlen;
      cost[2] += nlen(adj[b]);
      cost[3] += 5;
    end
    m = 0;
    for (int k = 1; k < 4; k++) if (cost[k] < cost[m]) m = k;
    exp_mode = 2'(m);
    exp_q[0] = sym(0, 5, ix[0]);
    exp_q[1] = sym(0, 2, m);
    for (int b = 0; b < nb - 1; b++) begin
      cx = b ? adj[b - 1] : (ix[0] - ctx_offset) & 31;
      case (m)
        0: exp_q[b + 2] = sym(b == nb - 2, clen, msk(cx * 32 + adj[b], clen));
        1: exp_q[b + 2] = sym(b == nb - 2, rlen, msk(adj[b], rlen));
        2: exp_q[b + 2] = sym(b == nb - 2, nlen(adj[b]), nc[adj[b]]);
        default: exp_q[b + 2] = sym(b == nb - 2, 5, adj[b]);
      endcase
    end
  endtask

  // offer one coefficient once the block is collecting
  task automatic put(int v, logic e);
    int t;
    t = 0;
    @(negedge mclk);
    while (coef_ready !== 1'b1 && t < 2000) begin
      @(negedge mclk);
      t++;
    end
    cmp_bit(2'(t < 2000), 2'h1);
    coef_valid = 1'b1;
    coef_data = 16'(v);
    coef_band_end = e;
  endtask

  // two coefficients a band whose mean square is exactly 2^(34-index), zero for index 39
  task automatic run_frame(int bw, int n, logic stl);
    int l;
    int t;
    nb = n;
    build_exp();
    @(negedge mclk);
    bw_sel = 2'(bw);
    stall = stl;
    clr = 1'b1;
    @(negedge mclk);
    clr = 1'b0;
    for (int b = 0; b < n; b++) begin
      l = 34 - raw[b];
      put(raw[b] == 39 ? 0 : 1 << (l + 1) / 2, 1'b0);
      put(raw[b] == 39 || l[0] ? 0 : 1 << l / 2, 1'b1);
    end
    @(negedge mclk);
    coef_valid = 1'b0;
    coef_band_end = 1'b0;
    // freeze the divider a few cycles; no symbol is in flight yet
    ce = 1'b0;
    repeat (3) @(negedge mclk);
    ce = 1'b1;
    if (stl) begin
      repeat (4 * n + 80) @(negedge mclk);
      cmp_bit({frame_done, sym_valid}, 2'h1); // fifo full, emission held back
      stall = 1'b0;
    end
    t = 0;
    while (frame_done !== 1'b1 && t < 1000) begin
      @(negedge mclk);
      t++;
    end
    cmp_bit(2'(t < 1000), 2'h1);
    t = 0;
    while (bnqc_writer_model_inst.cnt_q != n + 1 && t < 500) begin
      @(negedge mclk);
      t++;
    end
    repeat (4) @(negedge mclk);
    cmp_bit({1'b0, sym_valid}, 2'h0);
    cmp_sym(22'(bnqc_writer_model_inst.cnt_q), 22'(n + 1));
    cmp_bit(mode_out, exp_mode);
    cmp_sym(bnqc_writer_model_inst.got_q[0], exp_q[0]);
    cmp_sym(bnqc_writer_model_inst.got_q[1], exp_q[1]);
    for (int i = 2; i <= n; i++) cmp_sym(bnqc_writer_model_inst.got_q[i], exp_q[i]);
    $display("frame of %0d bands done", n);
  endtask

  // free-running clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // cycle ceiling guards against a hung handshake
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      $display("[ERR] %0t cycles %h limit %h", $time, cyc, 40000);
      wrap_up();
    end
  end

  // main sequence: mixed stalled frame, steep frame, resized and context frames
  initial begin
    {coef_valid, coef_band_end, tbl_we, tbl_sel, stall, clr} = '0;
    {num_errors, checks_done, cyc} = '0;
    ce = 1'b1;
    arst_n = 1'b0;
    bw_sel = 2'h0;
    ctx_offset = 6'h05;
    coef_data = 16'h0000;
    tbl_addr = 10'h000;
    tbl_len = 5'h00;
    tbl_code = 16'h0000;
    repeat (4) @(negedge mclk);
    cmp_bit({coef_ready, sym_valid}, 2'h2);
    cmp_bit(mode_out, 2'h3);
    @(negedge mclk);
    arst_n = 1'b1;
    $display("reset levels done");
    load_tbls(16, 16);
    for (int b = 0; b < 26; b++) raw[b] = b % 6 == 1 ? 19 : b % 6 == 3 ? 24 : b % 6 == 4 ? 27 : 18;
    run_frame(0, 26, 1'b1);
    for (int b = 0; b < 39; b++) raw[b] = b[0] ? 22 + b / 2 % 9 : 6 + b / 2 % 9;
    raw[0] = 34;
    raw[38] = 39;
    run_frame(2, 39, 1'b0);
    load_tbls(1, 16);
    for (int b = 0; b < 44; b++) raw[b] = 18;
    run_frame(1, 44, 1'b0);
    load_tbls(16, 2);
    for (int b = 0; b < 39; b++) raw[b] = 18 + b % 3;
    run_frame(3, 39, 1'b0);
    wrap_up();
  end
endmodule
`default_nettype wire

/* verification/bnqc_writer_model.sv */
// bitstream writer model that accepts and records envelope symbols
`timescale 1ns/1ns
`default_nettype none
module bnqc_writer_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // bench control
  input  wire logic        stall,
  input  wire logic        clr,
  // symbol stream
  input  wire logic        sym_valid,
  output logic             sym_ready,
  input  wire logic [15:0] sym_code,
  input  wire logic [4:0]  sym_len,
  input  wire logic        sym_last
);
  logic [21:0] got_q [0:63];
  int          cnt_q;
  // ready follows the stall request one edge later, like a busy writer
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) sym_ready <= 1'b0;
    else sym_ready <= !stall;
  end
  // record each accepted symbol as last flag, bit count and right-aligned code
  always @(posedge clk) begin
    if (clr) cnt_q <= 0;
    else if (sym_valid && sym_ready) begin
      got_q[cnt_q] <= {sym_last, sym_len, sym_code};
      cnt_q <= cnt_q + 1;
    end
  end
endmodule
`default_nettype wire
